/* File: logic/nlf_defs.svh */
// Purpose: constants of the NVM configuration loader
// Assumes: word offsets are NVM word addresses
// Notes: included by bare name
`ifndef NLF_DEFS_SVH
`define NLF_DEFS_SVH
// word offsets, also the register port offsets
`define NLF_W_RSVD_A   8'h1D
`define NLF_W_REV      8'h1E
`define NLF_W_LED      8'h1F
`define NLF_W_FLASH    8'h20
`define NLF_W_BOOT     8'h21
`define NLF_W_STATUS   8'h30
`define NLF_NWORDS     5
// hardware defaults of the five words
`define NLF_RST_RSVD_A 16'h0100
`define NLF_RST_REV    16'h4300
`define NLF_RST_LED    16'h0706
`define NLF_RST_FLASH  16'h6000
`define NLF_RST_BOOT   16'h0000
// indicator word fields, per indicator byte
`define NLF_LINK_LSB   0
`define NLF_SPEED_LSB  8
`define NLF_MODE_LSB   0
`define NLF_RATE_BIT   5
`define NLF_POL_BIT    6
`define NLF_BLINK_BIT  7
// flash parameter word fields
`define NLF_ERASE_LSB  8
`define NLF_TYPE_BIT   5
`define NLF_LONG_BIT   4
// boot window word fields
`define NLF_FWDIS_BIT  15
`define NLF_SIZE_LSB   12
`define NLF_LOC_LSB    8
`define NLF_ROMDIS_BIT 7
// status register fields
`define NLF_ST_DONE    0
`define NLF_ST_IMAGE   1
// sizes
`define NLF_NO_ERASE   8'h00
`define NLF_BURST_MAX  9'h100
`define NLF_SINGLE_MAX 9'h001
`define NLF_WIN_UNIT   19'h00800
`define NLF_LOC_UNIT   17'h01000
// timing
`define NLF_CLK_HZ     20000000
`define NLF_SLOW_MS    200
`define NLF_FAST_MS    83
`define NLF_SLOW_CYC   (`NLF_SLOW_MS * (`NLF_CLK_HZ / 1000))
`define NLF_FAST_CYC   (`NLF_FAST_MS * (`NLF_CLK_HZ / 1000))
`endif

/* File: logic/nlf_pkg.sv */
// Purpose: types of the NVM configuration loader
// Assumes: constants live in nlf_defs.svh
// Notes: none
`default_nettype none
package nlf_pkg;
  // one indicator's settings
  typedef struct packed {
    logic [3:0] mode;
    logic       fast;
    logic       pol;
    logic       blink_en;
  } nlf_led_cfg_s;
  // settings handed to the flash controller
  typedef struct packed {
    logic [7:0] chip_erase_opcode;
    logic       erase_supported;
    logic       byte_write_flash_type_n;
    logic       long_write_cycle;
    logic [8:0] max_write_bytes;
  } nlf_flash_cfg_s;
  // loader sequence
  typedef enum logic [1:0] {
    NLF_ST_START = 2'b00,
    NLF_ST_REQ   = 2'b01,
    NLF_ST_WAIT  = 2'b10,
    NLF_ST_DONE  = 2'b11
  } nlf_state_e;
endpackage : nlf_pkg
`default_nettype wire

/* File: logic/nlf_config_loader.sv */
// Purpose: loads and applies indicator and flash configuration words
// Assumes: nvm read port answers with nvm_valid some cycles after nvm_rd
// Notes: software may rewrite the indicator, flash and boot words once loading is done
`include "nlf_defs.svh"
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - link indicator mode comes from bits 3:0 of the indicator word, default 0x6, code 0010b shows link up.
// - speed indicator mode comes from bits 11:8 of the indicator word, default 0x7, code 0110b shows 100 Mb/s.
// - blink rate bits 5 and 13 select 200 ms on/off when 0 and 83 ms on/off when 1.
// - polarity bits 6 and 14 set to 0 (the default) make the indicator output active low.
// - blink enable bits 7 and 15 at 0 (the default) keep the indicator steady.
// - bits 15:8 of the flash parameter word are the whole-device erase opcode, default 0x60.
// - an erase opcode of 0x00 means no whole-device erase is ever issued.
// - flash type bit 5 at 0 limits writes to one byte and requests clearing write protection at power-up.
// - flash type bit 5 at 1 allows burst writes up to 256 bytes and skips clearing write protection.
// - long cycle bit 4 at 1 marks flash writes as very long cycles, at 0 as normal cycles.
// - bit 15 of the boot window word at 1 disables the flash window seen by the host.
// - boot window size is 2 KB shifted left by the 3-bit field in bits 14:12.
// - boot image word address is 4 KB times the sum of bits 11:8 and the end offset term.
// - bit 7 of the boot window word at 1 disables the boot ROM window, the image sets it to 1.
module nlf_config_loader
  import nlf_pkg::*;
#(
  parameter int unsigned CNT_W     = 22,
  parameter int unsigned SLOW_CYC  = `NLF_SLOW_CYC,
  parameter int unsigned FAST_CYC  = `NLF_FAST_CYC
)(
  // clock and reset
  input  wire logic           clk_sys,
  input  wire logic           nrst,
  // nvm read port
  input  wire logic           nvm_image_ok,
  output logic                nvm_rd,
  output logic [7:0]          nvm_addr,
  input  wire logic           nvm_valid,
  input  wire logic [15:0]    nvm_data,
  // register port
  input  wire logic [7:0]     reg_addr,
  input  wire logic [15:0]    reg_wdata,
  input  wire logic           reg_wr,
  input  wire logic           reg_rd,
  output logic [15:0]         reg_rdata,
  // indicator events, one bit per mode code
  input  wire logic [15:0]    led_event,
  output logic                link_led,
  output logic                speed_led,
  // flash controller side
  output nlf_flash_cfg_s      flash_cfg,
  input  wire logic           erase_req,
  output logic                erase_cmd,
  output logic                erase_refused,
  output logic                clear_wp_req,
  // boot window side
  input  wire logic [3:0]     boot_end_offset,
  output logic                flash_window_en,
  output logic                boot_rom_window_en,
  output logic [18:0]         boot_window_bytes,
  output logic [16:0]         boot_image_addr,
  output logic                cfg_done
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // index of a word offset inside the array, or NWORDS when unmapped
  function automatic logic [2:0] word_idx(input logic [7:0] a);
    logic [2:0] r;
    r = 3'(`NLF_NWORDS);
    if (a >= `NLF_W_RSVD_A && a <= `NLF_W_BOOT)
    begin
      r = 3'(a - `NLF_W_RSVD_A);
    end
    return r;
  endfunction : word_idx

  // unpack one indicator byte
  function automatic nlf_led_cfg_s led_cfg(input logic [7:0] b);
    nlf_led_cfg_s c;
    c.mode     = b[`NLF_MODE_LSB +: 4];
    c.fast     = b[`NLF_RATE_BIT];
    c.pol      = b[`NLF_POL_BIT];
    c.blink_en = b[`NLF_BLINK_BIT];
    return c;
  endfunction : led_cfg

  ////////////////////////////////////////////////////////////////////////////
  // loader and register file state

  logic [15:0]  word_reg  [`NLF_NWORDS];
  logic [15:0]  word_next [`NLF_NWORDS];
  nlf_state_e   state_reg;
  nlf_state_e   state_next;
  logic [2:0]   idx_reg;
  logic [2:0]   idx_next;
  logic         image_reg;
  logic         image_next;
  logic         wp_reg;
  logic         wp_next;
  logic [15:0]  rdata_reg;
  logic [15:0]  rdata_next;
  logic [2:0]   reg_idx;

  assign reg_idx = word_idx(reg_addr);

  // loader steps through the words; software writes only after it ends
  always_comb
  begin
    state_next = state_reg;
    idx_next   = idx_reg;
    image_next = image_reg;
    wp_next    = 1'b0;
    rdata_next = 16'h0000;
    for (int i = 0; i < `NLF_NWORDS; i++)
    begin
      word_next[i] = word_reg[i];
    end
    unique case (state_reg)
      NLF_ST_START:
      begin
        if (nvm_image_ok)
        begin
          image_next = 1'b1;
          state_next = NLF_ST_REQ;
        end
        else
        begin
          state_next = NLF_ST_DONE;
          wp_next    = ~word_reg[3][`NLF_TYPE_BIT];
        end
      end
      NLF_ST_REQ:
      begin
        state_next = NLF_ST_WAIT;
      end
      NLF_ST_WAIT:
      begin
        if (nvm_valid)
        begin
          word_next[idx_reg] = nvm_data;
          if (idx_reg == 3'(`NLF_NWORDS - 1))
          begin
            state_next = NLF_ST_DONE;
            // type bit sits in the flash word, already stored by now
            wp_next    = ~word_reg[3][`NLF_TYPE_BIT];
          end
          else
          begin
            idx_next   = idx_reg + 3'h1;
            state_next = NLF_ST_REQ;
          end
        end
      end
      NLF_ST_DONE:
      begin
        if (reg_wr && reg_idx >= 3'h2 && reg_idx != 3'(`NLF_NWORDS))
        begin
          word_next[reg_idx] = reg_wdata;
        end
      end
    endcase
    // read data shown only in the cycle after the strobe
    if (reg_rd)
    begin
      if (reg_addr == `NLF_W_STATUS)
      begin
        rdata_next[`NLF_ST_DONE]  = (state_reg == NLF_ST_DONE);
        rdata_next[`NLF_ST_IMAGE] = image_reg;
      end
      else if (reg_idx != 3'(`NLF_NWORDS))
      begin
        rdata_next = word_reg[reg_idx];
      end
    end
  end

  // register the loader state
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      state_reg   <= NLF_ST_START;
      idx_reg     <= 3'h0;
      image_reg   <= 1'b0;
      wp_reg      <= 1'b0;
      rdata_reg   <= 16'h0000;
      word_reg[0] <= `NLF_RST_RSVD_A;
      word_reg[1] <= `NLF_RST_REV;
      word_reg[2] <= `NLF_RST_LED;
      word_reg[3] <= `NLF_RST_FLASH;
      word_reg[4] <= `NLF_RST_BOOT;
    end
    else
    begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      image_reg <= image_next;
      wp_reg    <= wp_next;
      rdata_reg <= rdata_next;
      for (int i = 0; i < `NLF_NWORDS; i++)
      begin
        word_reg[i] <= word_next[i];
      end
    end
  end

  assign nvm_rd       = (state_reg == NLF_ST_REQ);
  assign nvm_addr     = `NLF_W_RSVD_A + 8'(idx_reg);
  assign reg_rdata    = rdata_reg;
  assign clear_wp_req = wp_reg;
  assign cfg_done     = (state_reg == NLF_ST_DONE);

  ////////////////////////////////////////////////////////////////////////////
  // flash and boot window settings

  logic [7:0] opcode;
  assign opcode = word_reg[3][`NLF_ERASE_LSB +: 8];

  // decoded straight from the stored words
  always_comb
  begin
    flash_cfg.chip_erase_opcode       = opcode;
    flash_cfg.erase_supported         = (opcode != `NLF_NO_ERASE);
    flash_cfg.byte_write_flash_type_n = word_reg[3][`NLF_TYPE_BIT];
    flash_cfg.long_write_cycle        = word_reg[3][`NLF_LONG_BIT];
    flash_cfg.max_write_bytes         = word_reg[3][`NLF_TYPE_BIT] ?
                                        `NLF_BURST_MAX : `NLF_SINGLE_MAX;
  end

  assign flash_window_en    = ~word_reg[4][`NLF_FWDIS_BIT];
  assign boot_rom_window_en = ~word_reg[4][`NLF_ROMDIS_BIT];
  assign boot_window_bytes  = `NLF_WIN_UNIT << word_reg[4][`NLF_SIZE_LSB +: 3];
  assign boot_image_addr    = 17'(`NLF_LOC_UNIT *
                              (17'(word_reg[4][`NLF_LOC_LSB +: 4]) + 17'(boot_end_offset)));

  ////////////////////////////////////////////////////////////////////////////
  // erase command gate

  logic erase_reg;
  logic erase_next;
  logic refuse_reg;
  logic refuse_next;

  // a zero opcode turns every request into a refusal; none before loading ends
  always_comb
  begin
    erase_next  = 1'b0;
    refuse_next = 1'b0;
    if (erase_req && cfg_done)
    begin
      erase_next  = flash_cfg.erase_supported;
      refuse_next = ~flash_cfg.erase_supported;
    end
  end

  // register the erase pulses
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      erase_reg  <= 1'b0;
      refuse_reg <= 1'b0;
    end
    else
    begin
      erase_reg  <= erase_next;
      refuse_reg <= refuse_next;
    end
  end

  assign erase_cmd     = erase_reg;
  assign erase_refused = refuse_reg;

  ////////////////////////////////////////////////////////////////////////////
  // indicator outputs

  nlf_led_cfg_s  led_c [2];
  logic [CNT_W-1:0] cnt_reg  [2];
  logic [CNT_W-1:0] cnt_next [2];
  logic [1:0]    phase_reg;
  logic [1:0]    phase_next;
  logic [1:0]    led_reg;
  logic [1:0]    led_next;

  assign led_c[0] = led_cfg(word_reg[2][`NLF_LINK_LSB +: 8]);
  assign led_c[1] = led_cfg(word_reg[2][`NLF_SPEED_LSB +: 8]);

  // separate timers so each indicator keeps its own rate
  always_comb
  begin
    logic on;
    logic [CNT_W-1:0] lim;
    on  = 1'b0;
    lim = '0;
    for (int i = 0; i < 2; i++)
    begin
      lim = led_c[i].fast ? CNT_W'(FAST_CYC - 1) : CNT_W'(SLOW_CYC - 1);
      cnt_next[i]   = cnt_reg[i] + 1'b1;
      phase_next[i] = phase_reg[i];
      if (cnt_reg[i] >= lim)
      begin
        cnt_next[i]   = '0;
        phase_next[i] = ~phase_reg[i];
      end
      on = led_event[led_c[i].mode];
      if (led_c[i].blink_en)
      begin
        on = on & phase_reg[i];
      end
      led_next[i] = led_c[i].pol ? on : ~on;
    end
  end

  // register the indicator timers and pins
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      cnt_reg[0] <= '0;
      cnt_reg[1] <= '0;
      phase_reg  <= 2'h0;
      led_reg    <= 2'h3;
    end
    else
    begin
      cnt_reg[0] <= cnt_next[0];
      cnt_reg[1] <= cnt_next[1];
      phase_reg  <= phase_next;
      led_reg    <= led_next;
    end
  end

  assign link_led  = led_reg[0];
  assign speed_led = led_reg[1];

endmodule : nlf_config_loader
`default_nettype wire

/* File: tb/nlf_config_loader_props.sv */
// Purpose: port checks of the nvm configuration loader
// Assumes: one clock, sync reset nrst low
// Notes: bound to every loader instance
`timescale 1ns/1ps
`default_nettype none
module nlf_config_loader_props
  import nlf_pkg::*;
(
  // clock and reset
  input wire logic           clk_sys,
  input wire logic           nrst,
  // watched ports
  input wire logic           reg_rd,
  input wire logic [15:0]    reg_rdata,
  input wire nlf_flash_cfg_s flash_cfg,
  input wire logic           erase_req,
  input wire logic           erase_cmd,
  input wire logic           erase_refused,
  input wire logic           clear_wp_req,
  input wire logic           flash_window_en,
  input wire logic           boot_rom_window_en,
  input wire logic           cfg_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  // flash settings and erase answers
  a_erase_issue: assert property (erase_req && cfg_done && flash_cfg.chip_erase_opcode != 8'h00 |=> erase_cmd)
    else $error("erase not issued");
  a_erase_refuse: assert property (erase_req && cfg_done && flash_cfg.chip_erase_opcode == 8'h00
    |=> erase_refused && !erase_cmd) else $error("zero opcode erase not refused");
  a_erase_flag: assert property (flash_cfg.erase_supported == (flash_cfg.chip_erase_opcode != 8'h00))
    else $error("erase support flag wrong");
  a_write_size: assert property (flash_cfg.max_write_bytes ==
    (flash_cfg.byte_write_flash_type_n ? 9'h100 : 9'h001)) else $error("write size wrong");
  // load sequence; a second reset must bring the defaults back
  a_rst_dflt: assert property (!$past(nrst) |-> flash_cfg.chip_erase_opcode == 8'h60 &&
    flash_window_en && boot_rom_window_en && !cfg_done) else $error("defaults missing after reset");
  a_done_hold: assert property (cfg_done |=> cfg_done)
    else $error("done dropped");
  a_wp_done: assert property ($rose(cfg_done) |-> clear_wp_req == !flash_cfg.byte_write_flash_type_n)
    else $error("write protect request wrong at load end");
  a_wp_only: assert property (clear_wp_req |-> $rose(cfg_done))
    else $error("write protect request outside load end");
  // read data stands only after a read strobe
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data without read");
  c_erase: cover property (erase_cmd);
  c_refuse: cover property (erase_refused);
  c_wp: cover property ($rose(cfg_done) && clear_wp_req);
endmodule : nlf_config_loader_props
bind nlf_config_loader nlf_config_loader_props u_props (.clk_sys, .nrst, .reg_rd, .reg_rdata, .flash_cfg,
  .erase_req, .erase_cmd, .erase_refused, .clear_wp_req, .flash_window_en, .boot_rom_window_en, .cfg_done);
`default_nettype wire

/* File: tb/nlf_nvm_model.sv */
// Purpose: nvm holding the five configuration words
// Assumes: word 0x1D sits in img[15:0]
// Notes: answers lat+1 cycles after a read
`timescale 1ns/1ps
`default_nettype none
module nlf_nvm_model (
  // clock and read port
  input  wire logic        clk_sys,
  input  wire logic        nvm_rd,
  input  wire logic [7:0]  nvm_addr,
  // image and delay
  input  wire logic [79:0] img,
  input  wire logic [3:0]  lat,
  output logic             nvm_valid = 1'b0,
  output logic [15:0]      nvm_data = 16'h0000
);
  logic [3:0]  cnt_reg = 4'h0;
  logic        busy_reg = 1'b0;
  logic [15:0] word;
  // reserved bits leave the image as zero
  always_comb
  begin
    word = img[16 * (nvm_addr - 8'h1D) +: 16];
    if (nvm_addr == 8'h1F)
      word = word & 16'hEFEF;
    if (nvm_addr == 8'h21)
      word = word & 16'hFF80;
  end
  // idle data flips so stale data never passes
  always_ff @(posedge clk_sys)
  begin
    nvm_valid <= 1'b0;
    nvm_data  <= ~nvm_data;
    if (nvm_rd)
    begin
      busy_reg <= 1'b1;
      cnt_reg  <= lat;
    end
    else if (busy_reg && cnt_reg == 4'h0)
    begin
      busy_reg  <= 1'b0;
      nvm_valid <= 1'b1;
      nvm_data  <= word;
    end
    else if (busy_reg)
      cnt_reg <= cnt_reg - 4'h1;
  end
endmodule : nlf_nvm_model
`default_nettype wire

/* File: tb/nlf_config_loader_tb_top.sv */
// Purpose: self-checking bench of the loader
// Assumes: blink counts cut to 20 and 8
// Notes: end offset term 2, then 3 after the second reset
`timescale 1ns/1ps
`default_nettype none
module nlf_config_loader_tb_top import nlf_pkg::*;;
  logic           clk_sys = 1'b0, nrst = 1'b0, nvm_image_ok = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic           erase_req = 1'b0, nvm_rd, nvm_valid, link_led, speed_led, erase_cmd, erase_refused;
  logic           clear_wp_req, flash_window_en, boot_rom_window_en, cfg_done;
  logic [7:0]     reg_addr = 8'h00, nvm_addr;
  logic [15:0]    reg_wdata = 16'h0000, led_event = 16'h0000, reg_rdata, nvm_data;
  logic [3:0]     boot_end_offset = 4'h2, lat = 4'h3;
  logic [79:0]    img = 80'h0;
  logic [18:0]    boot_window_bytes;
  logic [16:0]    boot_image_addr;
  nlf_flash_cfg_s flash_cfg;
  int             n_mismatch = 0, comparisons = 0, n_wp;
  nlf_config_loader #(.SLOW_CYC(20), .FAST_CYC(8)) dut (.clk_sys, .nrst, .nvm_image_ok, .nvm_rd, .nvm_addr,
    .nvm_valid, .nvm_data, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .led_event, .link_led,
    .speed_led, .flash_cfg, .erase_req, .erase_cmd, .erase_refused, .clear_wp_req, .boot_end_offset,
    .flash_window_en, .boot_rom_window_en, .boot_window_bytes, .boot_image_addr, .cfg_done);
  nlf_nvm_model u_nvm (.clk_sys, .nvm_rd, .nvm_addr, .img, .lat, .nvm_valid, .nvm_data);
  // 50 ns clock
  initial
  begin
    forever #25 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic close_out;
    $display("counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic boot(input logic ok);
    @(posedge clk_sys);
    nrst <= 1'b0;
    nvm_image_ok <= ok;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
  endtask : boot
  // bounded wait for load end, counting protect requests
  task automatic wait_done;
    n_wp = 0;
    for (int i = 0; i < 200 && cfg_done !== 1'b1; i++)
    begin
      @(posedge clk_sys);
      #1 n_wp += clear_wp_req;
    end
    if (cfg_done !== 1'b1)
    begin
      n_mismatch++;
      close_out();
    end
  endtask : wait_done
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), reg_rdata, e);
  endtask : rc
  // n requests back to back
  task automatic er(input int n, input logic c, input logic f);
    @(posedge clk_sys);
    erase_req <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      if (i == n - 1)
        erase_req <= 1'b0;
      #1 chk("erase_cmd", erase_cmd, c);
      chk("erase_refused", erase_refused, f);
    end
  endtask : er
  // longer than a slow blink half period
  task automatic led(input logic [15:0] v);
    @(posedge clk_sys);
    led_event <= v;
    repeat (25) @(posedge clk_sys);
    #1;
  endtask : led
  // first full interval between speed output changes
  task automatic gap(input int e);
    logic v;
    int   n;
    for (int k = 0; k < 2; k++)
    begin
      v = speed_led;
      n = 0;
      while (speed_led === v && n < 100)
      begin
        @(posedge clk_sys);
        #1 n++;
      end
    end
    chk("blink gap", n, e);
    if (n >= 100)
      close_out();
  endtask : gap
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_dflt;
    boot(1'b0);
    wait_done();
    chk("wp pulses", n_wp, 1);
    rc(8'h1D, 16'h0100);
    rc(8'h1E, 16'h4300);
    rc(8'h1F, 16'h0706);
    rc(8'h20, 16'h6000);
    rc(8'h21, 16'h0000);
    rc(8'h30, 16'h0001);
    chk("flash_cfg", flash_cfg, {8'h60, 1'b1, 1'b0, 1'b0, 9'h001});
    chk("windows", {flash_window_en, boot_rom_window_en}, 2'b11);
    chk("win bytes", boot_window_bytes, 19'h00800);
    chk("img addr", boot_image_addr, 17'h02000);
    led(16'h0040);
    chk("leds", {link_led, speed_led}, 2'b01);
    er(1, 1'b1, 1'b0);
  endtask : t_dflt
  task automatic t_load;
    img <= {16'hB580, 16'h0030, 16'hE642, 16'hF000, 16'h0100};
    boot(1'b1);
    boot_end_offset <= 4'h3;
    // indicator word is stored by now, the load is still running
    repeat (20) @(posedge clk_sys);
    wr(8'h1F, 16'h0000);
    wait_done();
    chk("wp pulses", n_wp, 0);
    rc(8'h1E, 16'hF000);
    rc(8'h1F, 16'hE642);
    rc(8'h20, 16'h0030);
    rc(8'h21, 16'hB580);
    rc(8'h30, 16'h0003);
    chk("flash_cfg", flash_cfg, {8'h00, 1'b0, 1'b1, 1'b1, 9'h100});
    chk("windows", {flash_window_en, boot_rom_window_en}, 2'b00);
    chk("win bytes", boot_window_bytes, 19'h04000);
    chk("img addr", boot_image_addr, 17'h08000);
    er(1, 1'b0, 1'b1);
    led(16'h0044);
    chk("link_led", link_led, 1'b1);
    gap(8);
  endtask : t_load
  task automatic t_sw;
    wr(8'h1F, 16'hC642);
    rc(8'h1F, 16'hC642);
    gap(20);
    wr(8'h20, 16'hC720);
    #1 chk("flash_cfg", flash_cfg, {8'hC7, 1'b1, 1'b1, 1'b0, 9'h100});
    er(2, 1'b1, 1'b0);
    wr(8'h1E, 16'h1234);
    rc(8'h1E, 16'hF000);
    rc(8'h55, 16'h0000);
  endtask : t_sw
  initial
  begin
    t_dflt();
    $display("test defaults done");
    t_load();
    $display("test load done");
    t_sw();
    $display("test software done");
    close_out();
  end
endmodule : nlf_config_loader_tb_top
`default_nettype wire
